// ### aow_pkg.sv
package aow_pkg;

    // Register bus geometry
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int CONV_W = 12;
    localparam int PAD_W = DATA_W - CONV_W;
    localparam int OW_W = 8;
    localparam int PERIOD_W = 4;

    // Register addresses
    localparam logic [ADDR_W-1:0] ADDR_OW = 20'hf06ba;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 20'hf06be;
    localparam logic [ADDR_W-1:0] ADDR_RESULT = 20'hf06c0;
    localparam logic [ADDR_W-1:0] ADDR_WINDOW = 20'hf06c2;

    // Register window values that expose the banked registers
    localparam logic [7:0] WIN_CTRL = 8'h00;
    localparam logic [7:0] WIN_OW = 8'h07;

    // Extended control field positions
    localparam int ALIGN_BIT = 15;
    localparam int SELFTEST_EN_BIT = 11;
    localparam int FIXED_SEL_BIT = 10;
    localparam int VSEL_MSB = 9;
    localparam int VSEL_LSB = 8;
    localparam int ACE_BIT = 5;
    localparam logic [DATA_W-1:0] CTRL_WMASK = 16'h8f20;

    // Open-wire assist field positions
    localparam int DIR_BIT = 4;
    localparam int PERIOD_MSB = 3;
    localparam logic [OW_W-1:0] OW_WMASK = 8'h1f;

    // Period codes
    localparam logic [PERIOD_W-1:0] PERIOD_OFF = 4'h0;
    localparam logic [PERIOD_W-1:0] PERIOD_BAD = 4'h1;
    localparam logic [PERIOD_W-1:0] PERIOD_MIN = 4'h2;

    // Reset values
    localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
    localparam logic [OW_W-1:0] OW_RST = 8'h00;
    localparam logic [7:0] WIN_RST = 8'h00;
    localparam logic [CONV_W-1:0] RESULT_RST = 12'h000;
    localparam logic [DATA_W-1:0] RDATA_IDLE = 16'h0000;

    // Register bus request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] wmask;
    } aow_bus_req_t;

    // Request towards the converter core
    typedef struct packed {
        logic start;
        logic use_internal;
        logic [1:0] vsel;
        logic assist_on;
        logic precharge;
    } aow_core_req_t;

    localparam aow_core_req_t CORE_REQ_RST = '0;

    // Conversion sequencer
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ASSIST = 2'b01,
        ST_START = 2'b11,
        ST_WAIT = 2'b10
    } aow_state_t;

endpackage

// ### aow_assist_timer.sv
`timescale 1ns/1ps
module aow_assist_timer #(
    parameter int CNT_W = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Control
    input wire logic load,
    input wire logic [CNT_W-1:0] period,
    // Status
    output logic last,
    output logic active
);

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    // Down counter, one step per assist cycle
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (load)
            cnt_nxt = period;
        else if (cnt_r != '0)
            cnt_nxt = cnt_r - CNT_W'(1);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    // Last tells the sequencer to drop assist on the next edge
    assign last = (cnt_r == CNT_W'(1));
    assign active = (cnt_r != '0);

    a_timer_load_value: assert property (@(posedge clk_sys) disable iff (rst)
        load |=> (cnt_r == $past(period))) else $error("assist timer did not load the period");

endmodule // aow_assist_timer

// ### aow_result_fmt.sv
`timescale 1ns/1ps
module aow_result_fmt
    import aow_pkg::*;
(
    // Alignment choice
    input wire logic align_left,
    // Raw conversion value
    input wire logic [CONV_W-1:0] value,
    // Register image
    output logic [DATA_W-1:0] word
);

    // Pad bits always read as zero on the unused side
    always_comb
    begin
        if (align_left)
            word = {value, {PAD_W{1'b0}}};
        else
            word = {{PAD_W{1'b0}}, value};
    end

endmodule // aow_result_fmt

// ### aow_ctrl.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
// Contract
// - Self-test converts an internal level (low reference, high reference or half of it) instead of an input.
// - Self-test and open-wire assist never run together; assist stays off while self-test is enabled.
// - With assist active, the sampling capacitor is charged or discharged before the conversion starts.
// - Bit 11 of the extended control register enables self-test when 1 and disables it when 0.
// - The two-bit level field picks 0 V (01), half reference (10) or full reference (11); 00 is not allowed.
// - With alignment 0 the result shows the value in bits 11 to 0 and zero in bits 15 to 12.
// - The result register holds the value converted from the internal level during self-test.
// - Bit 4 of the open-wire control chooses discharge when 0 and pre-charge when 1.
// - A period field of 0000 turns open-wire assist off completely.
// - Period codes 2 to 15 give that many assist cycles; software never writes code 1.
// - The open-wire control register accepts single-bit writes as well as full byte writes.
module aow_ctrl
    import aow_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register bus
    input wire aow_pkg::aow_bus_req_t bus_req,
    output logic [aow_pkg::DATA_W-1:0] bus_rdata,
    // Conversion trigger from the converter control
    input wire logic conv_trigger,
    // Converter core
    output aow_pkg::aow_core_req_t core_req,
    input wire logic conv_done,
    input wire logic [aow_pkg::CONV_W-1:0] conv_data
);
    import aow_pkg::*;

    // Register state
    logic [DATA_W-1:0] ctrl_r;
    logic [OW_W-1:0] ow_r;
    logic [7:0] window_r;
    logic [CONV_W-1:0] result_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    // Sequencer state
    aow_state_t state_r;
    aow_core_req_t core_req_r;

    // Decoded strobes
    logic ctrl_visible;
    logic ow_visible;
    logic wr_ctrl;
    logic wr_ow;
    logic wr_window;
    logic rd_result;
    logic assist_wanted;
    logic timer_load;
    logic timer_last;
    logic timer_active;
    logic [PERIOD_W-1:0] period_eff;
    logic [DATA_W-1:0] result_word;

    // Address match for one register
    function automatic logic addr_hit(input aow_bus_req_t b, input logic [ADDR_W-1:0] a);
        addr_hit = (b.addr == a);
    endfunction

    // Code 1 is illegal; the shortest legal assist is used so a stray write still precedes conversion
    function automatic logic [PERIOD_W-1:0] legal_period(input logic [PERIOD_W-1:0] p);
        legal_period = (p == PERIOD_BAD) ? PERIOD_MIN : p;
    endfunction

    // Banked registers are only reachable through their window
    assign ctrl_visible = (window_r == WIN_CTRL);
    assign ow_visible = (window_r == WIN_OW);
    assign wr_ctrl = bus_req.wr && addr_hit(bus_req, ADDR_CTRL) && ctrl_visible;
    assign wr_ow = bus_req.wr && addr_hit(bus_req, ADDR_OW) && ow_visible;
    assign wr_window = bus_req.wr && addr_hit(bus_req, ADDR_WINDOW);
    assign rd_result = bus_req.rd && addr_hit(bus_req, ADDR_RESULT);

    // Extended control, written as a whole word; fixed-zero bits stay zero
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ctrl_r <= CTRL_RST;
        else if (wr_ctrl)
            ctrl_r <= bus_req.wdata & CTRL_WMASK;
    end

    // Open-wire control, merged under the bit mask for bit or byte writes
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            ow_r <= OW_RST;
        else if (wr_ow)
            ow_r <= ((ow_r & ~bus_req.wmask[OW_W-1:0]) | (bus_req.wdata[OW_W-1:0] & bus_req.wmask[OW_W-1:0]))
                    & OW_WMASK;
    end

    // Register window selector
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            window_r <= WIN_RST;
        else if (wr_window)
            window_r <= bus_req.wdata[7:0];
    end

    // Assist only runs with a nonzero period and self-test off
    assign period_eff = legal_period(ow_r[PERIOD_MSB:0]);
    assign assist_wanted = (ow_r[PERIOD_MSB:0] != PERIOD_OFF) && !ctrl_r[SELFTEST_EN_BIT];
    assign timer_load = (state_r == ST_IDLE) && conv_trigger && assist_wanted;

    aow_assist_timer #(
        .CNT_W(PERIOD_W)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .load(timer_load),
        .period(period_eff),
        .last(timer_last),
        .active(timer_active)
    );

    // Conversion sequencer; settings are latched at the trigger so
    // a register write during a conversion cannot change its source
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_r <= ST_IDLE;
            core_req_r <= CORE_REQ_RST;
        end
        else
        begin
            core_req_r.start <= 1'b0;
            unique case (state_r)
                ST_IDLE:
                begin
                    if (conv_trigger)
                    begin
                        core_req_r.use_internal <= ctrl_r[SELFTEST_EN_BIT];
                        core_req_r.vsel <= ctrl_r[VSEL_MSB:VSEL_LSB];
                        core_req_r.precharge <= ow_r[DIR_BIT];
                        if (assist_wanted)
                        begin
                            core_req_r.assist_on <= 1'b1;
                            state_r <= ST_ASSIST;
                        end
                        else
                        begin
                            core_req_r.start <= 1'b1;
                            state_r <= ST_START;
                        end
                    end
                end
                ST_ASSIST:
                begin
                    if (timer_last)
                    begin
                        core_req_r.assist_on <= 1'b0;
                        core_req_r.start <= 1'b1;
                        state_r <= ST_START;
                    end
                end
                ST_START:
                begin
                    state_r <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (conv_done)
                    begin
                        core_req_r.use_internal <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Self-test result; a capture beats an auto-clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            result_r <= RESULT_RST;
        else if (state_r == ST_WAIT && conv_done && core_req_r.use_internal)
            result_r <= conv_data;
        else if (rd_result && ctrl_r[ACE_BIT])
            result_r <= RESULT_RST;
    end

    aow_result_fmt u_fmt (
        .align_left(ctrl_r[ALIGN_BIT]),
        .value(result_r),
        .word(result_word)
    );

    // Read mux; hidden banked registers and unmapped addresses read zero
    always_comb
    begin
        rdata_nxt = RDATA_IDLE;
        if (bus_req.rd)
        begin
            if (addr_hit(bus_req, ADDR_CTRL) && ctrl_visible)
                rdata_nxt = ctrl_r;
            else if (addr_hit(bus_req, ADDR_OW) && ow_visible)
                rdata_nxt = {{(DATA_W-OW_W){1'b0}}, ow_r};
            else if (addr_hit(bus_req, ADDR_WINDOW))
                rdata_nxt = {{(DATA_W-8){1'b0}}, window_r};
            else if (addr_hit(bus_req, ADDR_RESULT))
                rdata_nxt = result_word;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            rdata_r <= RDATA_IDLE;
        else
            rdata_r <= rdata_nxt;
    end

    assign bus_rdata = rdata_r;
    assign core_req = core_req_r;

    // Helper logic for checking assist length against the period
    logic [PERIOD_W:0] assist_len_r;
    logic [PERIOD_W-1:0] period_lat_r;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            assist_len_r <= '0;
            period_lat_r <= PERIOD_OFF;
        end
        else
        begin
            if (timer_load)
                period_lat_r <= period_eff;
            if (core_req_r.assist_on)
                assist_len_r <= assist_len_r + (PERIOD_W+1)'(1);
            else
                assist_len_r <= '0;
        end
    end

    a_no_assist_diag: assert property (@(posedge clk_sys) disable iff (rst)
        core_req_r.assist_on |-> !core_req_r.use_internal) else $error("assist active during self-test");

    a_diag_source_sel: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == ST_IDLE && conv_trigger && ctrl_r[SELFTEST_EN_BIT])
        |=> (core_req_r.start && core_req_r.use_internal && !core_req_r.assist_on
             && core_req_r.vsel == $past(ctrl_r[VSEL_MSB:VSEL_LSB])))
        else $error("self-test did not select the internal level");

    a_assist_before_start: assert property (@(posedge clk_sys) disable iff (rst)
        timer_load |=> (core_req_r.assist_on && !core_req_r.start)[*2] ##[1:14] core_req_r.start)
        else $error("conversion started before assist ended");

    a_assist_length: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(core_req_r.assist_on) |-> (assist_len_r == {1'b0, period_lat_r}))
        else $error("assist length differs from period");

    a_period_zero_off: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == ST_IDLE && conv_trigger && ow_r[PERIOD_MSB:0] == PERIOD_OFF)
        |=> !core_req_r.assist_on ##1 !core_req_r.assist_on) else $error("assist ran with period zero");

    a_assist_direction: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(core_req_r.assist_on) |-> (core_req_r.precharge == $past(ow_r[DIR_BIT])))
        else $error("assist direction does not follow control");

    a_selftest_enable: assert property (@(posedge clk_sys) disable iff (rst)
        wr_ctrl |=> (ctrl_r[SELFTEST_EN_BIT] == $past(bus_req.wdata[SELFTEST_EN_BIT])))
        else $error("self-test enable not written");

    a_window_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (bus_req.wr && addr_hit(bus_req, ADDR_CTRL) && window_r != WIN_CTRL) |=> $stable(ctrl_r))
        else $error("extended control written outside its window");

    a_bit_write: assert property (@(posedge clk_sys) disable iff (rst)
        wr_ow |=> (ow_r == ((($past(ow_r) & ~$past(bus_req.wmask[OW_W-1:0]))
                   | ($past(bus_req.wdata[OW_W-1:0]) & $past(bus_req.wmask[OW_W-1:0]))) & OW_WMASK)))
        else $error("open-wire control merge wrong");

    a_result_capture: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == ST_WAIT && conv_done && core_req_r.use_internal) |=> (result_r == $past(conv_data)))
        else $error("self-test result not captured");

    a_right_align: assert property (@(posedge clk_sys) disable iff (rst)
        (rd_result && !ctrl_r[ALIGN_BIT]) |=> (bus_rdata == {{PAD_W{1'b0}}, $past(result_r)}))
        else $error("right aligned result wrong");

    a_left_align: assert property (@(posedge clk_sys) disable iff (rst)
        (rd_result && ctrl_r[ALIGN_BIT]) |=> (bus_rdata == {$past(result_r), {PAD_W{1'b0}}}))
        else $error("left aligned result wrong");

    a_reset_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> (ctrl_r == CTRL_RST && ow_r == OW_RST && !core_req_r.assist_on))
        else $error("control not cleared by reset");

    // Timer and flag must agree, or the core sees a torn assist window
    a_assist_timer_sync: assert property (@(posedge clk_sys) disable iff (rst)
        core_req_r.assist_on == timer_active)
        else $error("assist flag and timer disagree");

    a_start_pulse: assert property (@(posedge clk_sys) disable iff (rst)
        core_req_r.start |=> !core_req_r.start)
        else $error("start held longer than one cycle");

    a_diag_no_load: assert property (@(posedge clk_sys) disable iff (rst)
        ctrl_r[SELFTEST_EN_BIT] |-> !timer_load)
        else $error("assist armed during self-test");

    a_external_source: assert property (@(posedge clk_sys) disable iff (rst)
        (state_r == ST_IDLE && conv_trigger && !ctrl_r[SELFTEST_EN_BIT]) |=> !core_req_r.use_internal)
        else $error("internal level used with self-test off");

    a_assist_period_set: assert property (@(posedge clk_sys) disable iff (rst)
        core_req_r.assist_on |-> (period_lat_r != PERIOD_OFF))
        else $error("assist ran without a period");

    a_no_bad_period: assert property (@(posedge clk_sys) disable iff (rst)
        timer_load |-> (period_eff != PERIOD_BAD))
        else $error("timer loaded the illegal period code");

    a_direction_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (core_req_r.assist_on && $past(core_req_r.assist_on)) |-> $stable(core_req_r.precharge))
        else $error("assist direction changed mid assist");

    a_ow_window_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (bus_req.wr && addr_hit(bus_req, ADDR_OW) && window_r != WIN_OW) |=> $stable(ow_r))
        else $error("open-wire control written outside its window");

    a_hidden_read_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (bus_req.rd && addr_hit(bus_req, ADDR_CTRL) && window_r != WIN_CTRL) |=> (bus_rdata == RDATA_IDLE))
        else $error("hidden extended control read nonzero");

    a_ctrl_zero_bits: assert property (@(posedge clk_sys) disable iff (rst)
        (ctrl_r & ~CTRL_WMASK) == '0)
        else $error("extended control fixed bit set");

    a_ow_zero_bits: assert property (@(posedge clk_sys) disable iff (rst)
        (ow_r & ~OW_WMASK) == '0)
        else $error("open-wire control fixed bit set");

    a_auto_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (rd_result && ctrl_r[ACE_BIT] && !(state_r == ST_WAIT && conv_done && core_req_r.use_internal))
        |=> (result_r == RESULT_RST)) else $error("result not cleared by read");

endmodule // aow_ctrl

// ### aow_core_model.sv
`timescale 1ns/1ps
module aow_core_model
    import aow_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Request from the block and chosen latency
    input wire aow_pkg::aow_core_req_t core_req,
    input wire logic [3:0] lat,
    // Answer
    output logic conv_done,
    output logic [aow_pkg::CONV_W-1:0] conv_data
);
    import aow_pkg::*;

    // Level seen on the external pin, arbitrary
    localparam logic [CONV_W-1:0] EXT_VAL = 12'h5a3;

    logic busy_r;
    logic [3:0] cnt_r;
    logic [CONV_W-1:0] val_r;

    // Source latched at start, answer after lat cycles; data churns when not valid
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
            val_r <= 12'h000;
            conv_done <= 1'b0;
            conv_data <= 12'h000;
        end
        else if (core_req.start)
        begin
            busy_r <= 1'b1;
            cnt_r <= lat;
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
            if (!core_req.use_internal)
                val_r <= EXT_VAL;
            else if (core_req.vsel == 2'h1)
                val_r <= 12'h000;
            else if (core_req.vsel == 2'h2)
                val_r <= 12'h800;
            else if (core_req.vsel == 2'h3)
                val_r <= 12'hfff;
            else
                val_r <= 12'h3c3;
        end
        else if (busy_r && cnt_r <= 4'h1)
        begin
            busy_r <= 1'b0;
            conv_done <= 1'b1;
            conv_data <= val_r;
        end
        else
        begin
            cnt_r <= cnt_r - 4'h1;
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
        end
    end
endmodule // aow_core_model

// ### aow_ctrl_tb.sv
`timescale 1ns/1ps
module aow_ctrl_tb;
    import aow_pkg::*;

    logic clk_sys;
    logic rst;
    aow_bus_req_t bus_req;
    logic [DATA_W-1:0] bus_rdata;
    logic conv_trigger;
    aow_core_req_t core_req;
    logic conv_done;
    logic [CONV_W-1:0] conv_data;
    logic [3:0] lat;
    int fails = 0;
    int total_checks = 0;

    aow_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .conv_trigger(conv_trigger), .core_req(core_req), .conv_done(conv_done), .conv_data(conv_data));

    aow_core_model core_u (.clk_sys(clk_sys), .rst(rst), .core_req(core_req), .lat(lat),
        .conv_done(conv_done), .conv_data(conv_data));

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    // Verdict in one place
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_num(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Whole-word write; mask only matters for the byte register
    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] m);
        @(posedge clk_sys);
        bus_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d, wmask: m};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic bus_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk_sys);
        bus_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000, wmask: 16'h0000};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1;
        chk_word(bus_rdata, e);
    endtask

    // One conversion: count assist cycles and the start cycle, then wait for the core
    task automatic conv_run(input int p, input logic pre, input logic intl, input logic [1:0] vs);
        int k;
        int na;
        na = 0;
        @(posedge clk_sys);
        conv_trigger <= 1'b1;
        @(posedge clk_sys);
        conv_trigger <= 1'b0;
        for (k = 1; k < 40; k++)
        begin
            #1;
            if (core_req.start === 1'b1)
                break;
            if (core_req.assist_on === 1'b1)
            begin
                na++;
                chk_word(16'(core_req.precharge), 16'(pre));
            end
            @(posedge clk_sys);
        end
        chk_num(k, p + 1);
        chk_num(na, p);
        chk_word(16'(core_req.use_internal), 16'(intl));
        if (intl)
            chk_word(16'(core_req.vsel), 16'(vs));
        for (k = 0; k < 60; k++)
        begin
            if (conv_done === 1'b1)
                break;
            @(posedge clk_sys);
            #1;
        end
        if (k == 60)
        begin
            fails++;
            stop_test();
        end
        @(posedge clk_sys);
        #1;
        chk_word(16'(core_req.use_internal), 16'h0000);
    endtask

    task automatic t_reset();
        chk_word(16'(core_req), 16'h0000);
        bus_rd(ADDR_CTRL, 16'h0000);
        bus_rd(ADDR_OW, 16'h0000);
        bus_rd(ADDR_RESULT, 16'h0000);
        bus_rd(ADDR_WINDOW, 16'h0000);
        $display("test reset done");
    endtask

    // Window gating, fixed-zero bits, bit writes, unmapped place
    task automatic t_regs();
        bus_wr(ADDR_CTRL, 16'hffff, 16'hffff);
        bus_rd(ADDR_CTRL, 16'h8f20);
        bus_wr(ADDR_WINDOW, 16'h0007, 16'hffff);
        bus_rd(ADDR_CTRL, 16'h0000);
        bus_wr(ADDR_CTRL, 16'h0000, 16'hffff);
        bus_wr(ADDR_OW, 16'h00ff, 16'h00ff);
        bus_rd(ADDR_OW, 16'h001f);
        bus_wr(ADDR_OW, 16'h0000, 16'h0010);
        bus_rd(ADDR_OW, 16'h000f);
        bus_rd(20'hf0000, 16'h0000);
        bus_wr(ADDR_WINDOW, 16'h0000, 16'hffff);
        bus_rd(ADDR_CTRL, 16'h8f20);
        bus_rd(ADDR_OW, 16'h0000);
        bus_wr(ADDR_CTRL, 16'h0000, 16'hffff);
        $display("test regs done");
    endtask

    // Every period boundary in both directions; code 1 is never written
    task automatic t_assist();
        logic [3:0] codes [4] = '{4'h0, 4'h2, 4'h3, 4'hf};
        bus_wr(ADDR_WINDOW, 16'h0007, 16'hffff);
        for (int i = 0; i < 4; i++)
        begin
            for (int d = 0; d < 2; d++)
            begin
                lat <= (d == 0) ? 4'h1 : 4'h9;
                bus_wr(ADDR_OW, {11'h000, d[0], codes[i]}, 16'h00ff);
                conv_run(int'(codes[i]), d[0], 1'b0, 2'h0);
            end
        end
        $display("test assist done");
    endtask

    // Internal levels in both alignments with assist armed
    task automatic t_selftest();
        logic [CONV_W-1:0] v;
        logic [1:0] vs;
        bus_wr(ADDR_WINDOW, 16'h0000, 16'hffff);
        for (int a = 0; a < 2; a++)
        begin
            for (int s = 1; s < 4; s++)
            begin
                vs = s[1:0];
                v = (vs == 2'h1) ? 12'h000 : (vs == 2'h2) ? 12'h800 : 12'hfff;
                lat <= (s == 2) ? 4'h7 : 4'h1;
                bus_wr(ADDR_CTRL, {a[0], 3'h0, 1'b1, 1'b1, vs, 8'h00}, 16'hffff);
                conv_run(0, 1'b0, 1'b1, vs);
                bus_rd(ADDR_RESULT, (a == 1) ? {v, 4'h0} : {4'h0, v});
            end
        end
        // Auto-clear: first read returns the full-reference level, second reads zero
        bus_wr(ADDR_CTRL, 16'h0020, 16'hffff);
        bus_rd(ADDR_RESULT, 16'h0fff);
        bus_rd(ADDR_RESULT, 16'h0000);
        bus_wr(ADDR_CTRL, 16'h0000, 16'hffff);
        conv_run(15, 1'b1, 1'b0, 2'h0);
        $display("test selftest done");
    endtask

    initial
    begin
        clk_sys = 1'b0;
        rst = 1'b1;
        bus_req = '0;
        conv_trigger = 1'b0;
        lat = 4'h2;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_assist();
        t_selftest();
        stop_test();
    end
endmodule // aow_ctrl_tb
